// [logic/pwm_timer_defines.svh]
// Register offsets, field positions and reset values of the PWM timer
`ifndef PWM_TIMER_DEFINES_SVH
`define PWM_TIMER_DEFINES_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define PWM1_MODE_CONTROL_ADDR 8'hdc
`define PWM1_COUNTER_ADDR      8'hdd
`define PWM1_RELOAD_DUTY_ADDR  8'hde

// ------------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------------
`define PIN_OE_BIT             0
`define RES_LO_BIT             1
`define RES_HI_BIT             2
`define CLK_SRC_BIT            3
`define RATE_LO_BIT            4
`define RATE_HI_BIT            6
`define RUN_BIT                7

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define PWM1_MODE_CONTROL_RST  8'h00
`define PWM1_COUNTER_RST       8'h00
`define PWM1_RELOAD_DUTY_RST   8'h00

// ------------------------------------------------------------------
// Period masks: the counter overflows when its masked bits are all one
// ------------------------------------------------------------------
`define PERIOD_MASK_256        8'hff
`define PERIOD_MASK_64         8'h3f
`define PERIOD_MASK_32         8'h1f
`define PERIOD_MASK_16         8'h0f

// Exponent of the largest prescale divisor for each clock source
`define PRESC_EXP_CPU          4'h8
`define PRESC_EXP_HOSC         4'h7

`endif

// [logic/pwm_timer_pkg.sv]
// Types shared by the PWM timer design
package pwm_timer_pkg;

    // PWM resolution, coded as the two-bit mode field
    typedef enum logic [1:0]
    {
        RES_256,
        RES_64,
        RES_32,
        RES_16
    } resolution_t;

    // One register byte
    typedef logic [7:0] reg_byte_t;

endpackage

// [logic/pwm_timer_eight_bit.sv]
// Eight-bit auto-reload PWM timer driving one shared GPIO pin
//
// Contract
// R1: 8-bit up counter, reload on overflow
// R2: Period starts high, ends low
// R3: Counter equals duty: output goes low
// R4: Overflow ends period, output returns high
// R5: Bits 2:1 pick 1/256, 1/64, 1/32, 1/16
// R6: Overflow every 256, 64, 32, 16 counts
// R7: Software keeps values inside resolution range
// R8: Bit 3 picks instruction or high clock
// R9: Instruction clock divided 256 down to 2
// R10: High clock divided 128 down to 1
// R11: Bit 7 stops or runs the timer
// R12: Waveform only with run and output enable
// R13: Bit 0 hands pin to PWM, else GPIO
// R14: Software configures mode before enabling timer
// R15: Software clears counter before enabling timer
// R16: Duty change applies from next period
// R17: Keeps running in low-power wakeup mode
// R18: Counts per prescaled tick, holds when stopped
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps

`include "pwm_timer_defines.svh"

module pwm_timer_eight_bit
(
    // Clock and reset
    input  wire logic       REF_CLK_IN,
    input  wire logic       SYS_RST_IN,
    // Register port
    input  wire logic [7:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    output logic      [7:0] RDATA_OUT,
    // Clock source strobes, one cycle per source clock period
    input  wire logic       FCPU_TICK_IN,
    input  wire logic       FHOSC_TICK_IN,
    // GPIO setting of the shared pin
    input  wire logic       GPIO_DATA_IN,
    input  wire logic       GPIO_OE_IN,
    // Shared pin
    output logic            SHARED_PWM_PIN_OUT,
    output logic            SHARED_PWM_PIN_OE_OUT
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    pwm_timer_pkg::reg_byte_t    mode_q;
    pwm_timer_pkg::reg_byte_t    count_q;
    pwm_timer_pkg::reg_byte_t    count_d;
    pwm_timer_pkg::reg_byte_t    reload_q;
    pwm_timer_pkg::reg_byte_t    duty_q;
    pwm_timer_pkg::reg_byte_t    presc_q;
    pwm_timer_pkg::reg_byte_t    presc_mask;
    pwm_timer_pkg::reg_byte_t    period_mask;
    pwm_timer_pkg::resolution_t  resolution;
    logic                        high_q;
    logic                        high_d;
    logic [3:0]                  presc_exp;
    logic [2:0]                  rate;
    logic                        timer_run_enable;
    logic                        clock_source_select;
    logic                        pwm_pin_output_enable;
    logic                        src_tick;
    logic                        tick;
    logic                        overflow;
    logic                        wr_mode;
    logic                        wr_count;
    logic                        wr_reload;

    // Strobes from the register port
    assign wr_mode   = WR_IN && (ADDR_IN == `PWM1_MODE_CONTROL_ADDR);
    assign wr_count  = WR_IN && (ADDR_IN == `PWM1_COUNTER_ADDR);
    assign wr_reload = WR_IN && (ADDR_IN == `PWM1_RELOAD_DUTY_ADDR);

    // Mode fields
    assign timer_run_enable      = mode_q[`RUN_BIT];                 // [R11]
    assign clock_source_select   = mode_q[`CLK_SRC_BIT];
    assign pwm_pin_output_enable = mode_q[`PIN_OE_BIT];
    assign rate       = mode_q[`RATE_HI_BIT:`RATE_LO_BIT];
    assign resolution =
        pwm_timer_pkg::resolution_t'(mode_q[`RES_HI_BIT:`RES_LO_BIT]);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------

    // Mode register, fully read/write
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            mode_q <= `PWM1_MODE_CONTROL_RST;
        else if (wr_mode)
            mode_q <= WDATA_IN;
    end

    // Reload register, write only; it sits as the first buffer stage
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            reload_q <= `PWM1_RELOAD_DUTY_RST;
        else if (wr_reload)
            reload_q <= WDATA_IN;
    end

    // Read data stand one cycle after the strobe and only there
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            RDATA_OUT <= 8'h00;
        else if (RD_IN && ADDR_IN == `PWM1_MODE_CONTROL_ADDR)
            RDATA_OUT <= mode_q;
        else if (RD_IN && ADDR_IN == `PWM1_COUNTER_ADDR)
            RDATA_OUT <= count_q;
        else
            RDATA_OUT <= 8'h00;  // Reload is write only; unmapped reads 0
    end

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------

    // Divisor is a power of two; the exponent shrinks by one per code
    // step, and the high clock starts one step lower than the cpu clock
    assign src_tick  = clock_source_select ? FHOSC_TICK_IN
                                           : FCPU_TICK_IN;      // [R8]
    assign presc_exp = (clock_source_select ? `PRESC_EXP_HOSC
                                            : `PRESC_EXP_CPU)
                       - {1'b0, rate};                     // [R9] [R10]
    assign presc_mask = 8'((9'h001 << presc_exp) - 9'h001);

    // Tick when the low exponent bits of the divider are all ones
    assign tick = timer_run_enable && src_tick
                  && ((presc_q & presc_mask) == presc_mask); // [R9] [R10]

    // Divider restarts from zero while stopped, so the first tick interval
    // after enabling is as long as every later one
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            presc_q <= 8'h00;
        else if (!timer_run_enable)
            presc_q <= 8'h00;
        else if (src_tick)
            presc_q <= presc_q + 8'h01;
    end

    // ------------------------------------------------------------------
    // Counter and period
    // ------------------------------------------------------------------

    // Period mask from the resolution field
    always_comb
    begin
        case (resolution)
            pwm_timer_pkg::RES_256: period_mask = `PERIOD_MASK_256; // [R5]
            pwm_timer_pkg::RES_64:  period_mask = `PERIOD_MASK_64;  // [R5]
            pwm_timer_pkg::RES_32:  period_mask = `PERIOD_MASK_32;  // [R5]
            pwm_timer_pkg::RES_16:  period_mask = `PERIOD_MASK_16;  // [R5]
            default:                period_mask = `PERIOD_MASK_256;
        endcase
    end

    // Out-of-range values are not trapped; software keeps them legal
    assign overflow = tick
                      && ((count_q & period_mask) == period_mask); // [R6] [R7]

    // Next count: a software write wins over counting
    always_comb
    begin
        if (wr_count)
            count_d = WDATA_IN;
        else if (overflow)
            count_d = reload_q;                            // [R1]
        else if (tick)
            count_d = count_q + 8'h01;                     // [R18]
        else
            count_d = count_q;                             // [R11] [R18]
    end

    // No power-mode input gates this: counting goes on in low power
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            count_q <= `PWM1_COUNTER_RST;
        else
            count_q <= count_d;                            // [R17]
    end

    // Working duty copy; follows the reload register while stopped,
    // then only at overflow so a period never sees a torn duty
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            duty_q <= `PWM1_RELOAD_DUTY_RST;
        else if (!timer_run_enable || overflow)
            duty_q <= reload_q;                            // [R16]
    end

    // ------------------------------------------------------------------
    // Waveform
    // ------------------------------------------------------------------

    // High phase begins each period, ends when count meets duty
    always_comb
    begin
        if (!timer_run_enable)
            high_d = 1'b1;                                 // [R2]
        else if (overflow)
            high_d = 1'b1;                                 // [R4]
        else if (tick && count_d == duty_q)
            high_d = 1'b0;                                 // [R3]
        else
            high_d = high_q;
    end

    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            high_q <= 1'b1;
        else
            high_q <= high_d;
    end

    // ------------------------------------------------------------------
    // Shared pin
    // ------------------------------------------------------------------

    // Pin stays low while handed to PWM but the timer is stopped; the
    // GPIO settings are never copied, so clearing bit 0 restores them
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            SHARED_PWM_PIN_OUT    <= 1'b0;
            SHARED_PWM_PIN_OE_OUT <= 1'b0;
        end
        else if (pwm_pin_output_enable)
        begin
            SHARED_PWM_PIN_OUT    <= timer_run_enable && high_q; // [R12]
            SHARED_PWM_PIN_OE_OUT <= 1'b1;                       // [R13]
        end
        else
        begin
            SHARED_PWM_PIN_OUT    <= GPIO_DATA_IN;               // [R13]
            SHARED_PWM_PIN_OE_OUT <= GPIO_OE_IN;                 // [R13]
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    // Counter: reload, advance and hold
    AST_RELOAD: assert property (@(posedge REF_CLK_IN) // [R1]
        disable iff (SYS_RST_IN)
        overflow && !wr_count |=> count_q == $past(reload_q))
        else $error("counter not reloaded at overflow");

    AST_COUNT_UP: assert property (@(posedge REF_CLK_IN) // [R18]
        disable iff (SYS_RST_IN)
        tick && !overflow && !wr_count
        |=> count_q == $past(count_q) + 8'h01)
        else $error("counter did not advance on tick");

    AST_HOLD_STOPPED: assert property (@(posedge REF_CLK_IN) // [R11]
        disable iff (SYS_RST_IN)
        !timer_run_enable && !wr_count |=> $stable(count_q))
        else $error("counter moved while stopped");

    // Waveform phases
    AST_HIGH_STOPPED: assert property (@(posedge REF_CLK_IN) // [R2]
        disable iff (SYS_RST_IN)
        !timer_run_enable |=> high_q)
        else $error("high phase not armed while stopped");

    AST_HIGH_AFTER_OVF: assert property (@(posedge REF_CLK_IN) // [R4]
        disable iff (SYS_RST_IN)
        overflow && pwm_pin_output_enable && !wr_mode
        |=> ##1 SHARED_PWM_PIN_OUT)
        else $error("pin not high at period start");

    AST_LOW_AT_DUTY: assert property (@(posedge REF_CLK_IN) // [R3]
        disable iff (SYS_RST_IN)
        tick && !overflow && !wr_count && count_q + 8'h01 == duty_q
        |=> !high_q)
        else $error("high phase did not end at duty");

    // Period length for each resolution
    AST_PERIOD_256: assert property (@(posedge REF_CLK_IN) // [R5]
        disable iff (SYS_RST_IN)
        tick && resolution == pwm_timer_pkg::RES_256
        && count_q == 8'hff |-> overflow)
        else $error("no overflow at 256-count boundary");

    AST_PERIOD_64: assert property (@(posedge REF_CLK_IN) // [R5]
        disable iff (SYS_RST_IN)
        tick && resolution == pwm_timer_pkg::RES_64
        && count_q[5:0] == 6'h3f |-> overflow)
        else $error("no overflow at 64-count boundary");

    AST_PERIOD_32: assert property (@(posedge REF_CLK_IN) // [R5]
        disable iff (SYS_RST_IN)
        tick && resolution == pwm_timer_pkg::RES_32
        && count_q[4:0] == 5'h1f |-> overflow)
        else $error("no overflow at 32-count boundary");

    AST_PERIOD_16: assert property (@(posedge REF_CLK_IN) // [R6]
        disable iff (SYS_RST_IN)
        tick && resolution == pwm_timer_pkg::RES_16 && count_q[3:0] == 4'hf
        |-> overflow)
        else $error("no overflow at 16-count boundary");

    // A wrong mask would cut the period short
    AST_NO_EARLY_OVF: assert property (@(posedge REF_CLK_IN) // [R6]
        disable iff (SYS_RST_IN)
        tick && resolution == pwm_timer_pkg::RES_16
        && count_q[3:0] != 4'hf |-> !overflow)
        else $error("overflow before 16-count boundary");

    // Prescaler and clock source
    AST_CPU_SOURCE: assert property (@(posedge REF_CLK_IN) // [R8]
        disable iff (SYS_RST_IN)
        tick && !clock_source_select |-> FCPU_TICK_IN)
        else $error("tick without instruction clock");

    AST_CPU_DIV2: assert property (@(posedge REF_CLK_IN) // [R9]
        disable iff (SYS_RST_IN)
        timer_run_enable && !clock_source_select && rate == 3'h7
        && FCPU_TICK_IN && !presc_q[0] |-> !tick)
        else $error("instruction clock not divided by two");

    AST_HOSC_DIV1: assert property (@(posedge REF_CLK_IN) // [R10]
        disable iff (SYS_RST_IN)
        timer_run_enable && clock_source_select && rate == 3'h7
        && FHOSC_TICK_IN |-> tick)
        else $error("high clock not passed undivided");

    // Duty copy and shared pin
    AST_DUTY_HELD: assert property (@(posedge REF_CLK_IN) // [R16]
        disable iff (SYS_RST_IN)
        timer_run_enable && !wr_mode && !overflow |=> $stable(duty_q))
        else $error("duty changed inside a period");

    AST_PIN_GATED: assert property (@(posedge REF_CLK_IN) // [R12]
        disable iff (SYS_RST_IN)
        pwm_pin_output_enable && !timer_run_enable
        |=> !SHARED_PWM_PIN_OUT)
        else $error("pin driven while timer stopped");

    AST_OE_PWM: assert property (@(posedge REF_CLK_IN) // [R13]
        disable iff (SYS_RST_IN)
        pwm_pin_output_enable |=> SHARED_PWM_PIN_OE_OUT)
        else $error("pin not driven while handed to PWM");

    AST_PIN_GPIO: assert property (@(posedge REF_CLK_IN) // [R13]
        disable iff (SYS_RST_IN)
        !pwm_pin_output_enable |=> SHARED_PWM_PIN_OUT == $past(GPIO_DATA_IN)
        && SHARED_PWM_PIN_OE_OUT == $past(GPIO_OE_IN))
        else $error("pin not returned to GPIO");

endmodule

// [verif/test_pwm_timer_eight_bit.sv]
// Self-checking testbench for the eight-bit PWM timer
`timescale 1ns/100ps

`include "pwm_timer_defines.svh"

module test_pwm_timer_eight_bit;

    // ------------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------------
    localparam int LIMIT = 60000;
    logic                      ref_clk    = 1'b0;
    logic                      sys_rst    = 1'b1;
    logic [7:0]                addr       = 8'h00;
    logic [7:0]                wdata      = 8'h00;
    logic                      wr_stb     = 1'b0;
    logic                      rd_stb     = 1'b0;
    pwm_timer_pkg::reg_byte_t  rdata;
    logic                      fcpu_tick  = 1'b0;
    logic                      fhosc_tick = 1'b1;
    logic                      gpio_data  = 1'b1;
    logic                      gpio_oe    = 1'b1;
    logic                      pin;
    logic                      pin_oe;
    int                        err_total   = 0;
    int                        checks_done = 0;
    int                        cycles      = 0;
    int                        span [4]    = '{256, 64, 32, 16};

    pwm_timer_eight_bit i_dut
    (
        .REF_CLK_IN            (ref_clk),
        .SYS_RST_IN            (sys_rst),
        .ADDR_IN               (addr),
        .WDATA_IN              (wdata),
        .WR_IN                 (wr_stb),
        .RD_IN                 (rd_stb),
        .RDATA_OUT             (rdata),
        .FCPU_TICK_IN          (fcpu_tick),
        .FHOSC_TICK_IN         (fhosc_tick),
        .GPIO_DATA_IN          (gpio_data),
        .GPIO_OE_IN            (gpio_oe),
        .SHARED_PWM_PIN_OUT    (pin),
        .SHARED_PWM_PIN_OE_OUT (pin_oe)
    );

    // Clock; the instruction strobe fires every other cycle so that the
    // two sources give different periods
    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
        fcpu_tick <= ~fcpu_tick;

    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_total++;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Bus tasks and compares
    // ------------------------------------------------------------------
    // Each access ends one edge later so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a,
                      output pwm_timer_pkg::reg_byte_t d);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
        @(posedge ref_clk);
    endtask

    task automatic chk_byte(input string what,
                            input pwm_timer_pkg::reg_byte_t exp,
                            input pwm_timer_pkg::reg_byte_t got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic exp,
                           input logic got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_count(input string what, input int exp,
                             input int got);
        checks_done++;
        if (got != exp)
        begin
            err_total++;
            $display("FAIL %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a,
                          input pwm_timer_pkg::reg_byte_t exp,
                          input string what);
        pwm_timer_pkg::reg_byte_t d;
        rd(a, d);
        chk_byte(what, exp, d);
    endtask

    // Configure first, load duty, clear count, then start
    task automatic pwm_start(input logic [7:0] m, input logic [7:0] duty);
        wr(`PWM1_MODE_CONTROL_ADDR, m & 8'h7f);
        wr(`PWM1_RELOAD_DUTY_ADDR, duty);
        wr(`PWM1_COUNTER_ADDR, 8'h00);
        wr(`PWM1_MODE_CONTROL_ADDR, m);
    endtask

    // Waits for a level on the pin, then counts cycles it lasts; looks
    // at every edge, so it sees what the previous edge launched and
    // never misses the first cycle of a level
    task automatic level_len(input logic lvl, output int n);
        n = 0;
        while (pin !== lvl)
        begin
            @(posedge ref_clk);
        end
        while (pin === lvl)
        begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        int h;
        int l;
        pwm_timer_pkg::reg_byte_t a;
        pwm_timer_pkg::reg_byte_t b;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Reset values, write-only and unmapped places read zero
        rd_chk(`PWM1_MODE_CONTROL_ADDR, 8'h00, "mode rst");
        rd_chk(`PWM1_COUNTER_ADDR, 8'h00, "count rst");
        rd_chk(`PWM1_RELOAD_DUTY_ADDR, 8'h00, "reload rst");
        rd_chk(8'h00, 8'h00, "unmapped");
        chk_pin("gpio pin", 1'b1, pin);
        chk_pin("gpio oe", 1'b1, pin_oe);
        wr(`PWM1_MODE_CONTROL_ADDR, 8'h5a);
        wr(`PWM1_COUNTER_ADDR, 8'h37);
        wr(`PWM1_RELOAD_DUTY_ADDR, 8'h21);
        rd_chk(`PWM1_MODE_CONTROL_ADDR, 8'h5a, "mode rw");
        rd_chk(`PWM1_COUNTER_ADDR, 8'h37, "count rw");
        rd_chk(`PWM1_RELOAD_DUTY_ADDR, 8'h00, "reload wo");
        gpio_data <= 1'b0;
        gpio_oe   <= 1'b0;
        wr(`PWM1_MODE_CONTROL_ADDR, 8'h7f);
        // Pin flops follow the mode register one edge later
        @(posedge ref_clk);
        chk_pin("stopped oe", 1'b1, pin_oe);
        chk_pin("stopped pin", 1'b0, pin);
        $display("test registers done");
        // Every resolution at full rate, duty 3
        for (int r = 0; r < 4; r++)
        begin
            pwm_start({4'hf, 1'b1, r[1:0], 1'b1}, 8'h03);
            level_len(1'b1, h);
            level_len(1'b0, l);
            chk_count("high", 3, h);
            chk_count("low", span[r] - 3, l);
        end
        $display("test resolution done");
        // Every rate of both sources, 16 counts, duty 2
        for (int s = 0; s < 2; s++)
            for (int r = 0; r < 8; r++)
            begin
                pwm_start({1'b1, r[2:0], s[0], 2'h3, 1'b1}, 8'h02);
                level_len(1'b1, h);
                level_len(1'b0, l);
                chk_count("rate low", (s == 1) ? 14 * (128 >> r)
                          : 28 * (256 >> r), l);
            end
        $display("test prescale done");
        // Duty written in mid-period waits for the reload
        // New duty lands inside the high phase; taken at once it would
        // stretch the high phase and shorten the low one
        pwm_start(8'hcf, 8'h03);
        wr(`PWM1_RELOAD_DUTY_ADDR, 8'h08);
        level_len(1'b1, h);
        level_len(1'b0, l);
        chk_count("old duty low", 104, l);
        rd_chk(`PWM1_COUNTER_ADDR, 8'h08, "reloaded");
        $display("test reload done");
        // Stopped counter holds; running counter follows ticks
        wr(`PWM1_MODE_CONTROL_ADDR, 8'h4f);
        rd(`PWM1_COUNTER_ADDR, a);
        repeat (20) @(posedge ref_clk);
        rd(`PWM1_COUNTER_ADDR, b);
        chk_byte("held", a, b);
        pwm_start(8'hf8, 8'h80);
        rd(`PWM1_COUNTER_ADDR, a);
        rd(`PWM1_COUNTER_ADDR, b);
        chk_byte("advance", a + 8'h02, b);
        chk_pin("run gpio oe", 1'b0, pin_oe);
        chk_pin("run gpio pin", 1'b0, pin);
        $display("test run hold done");
        test_done();
    end

endmodule
